//--- rtl/laser_ctrl_pkg.sv
// constants, register layout and types of the laser driver control logic
// What this block does
// RL1: eq code 00/01/11 gives 1/3/5.5 dB
// RL2: bias code is 9 bits, upper 8 written
// RL3: bias lsb zero at reset, step only
// RL4: bias step signed 5 bits added per write
// RL5: bias above limit loads limit, warns
// RL6: mod code 9 bits, lsb step only
// RL7: mod step signed 5 bits added per write
// RL8: mod above limit loads limit, warns
// RL9: controller adjusts codes by steps after init
// RL10: deemphasis from mode field and level
// RL11: reset clears enable, loads all defaults
// RL12: strap level sets address bits 6:5
// RL13: unmasked hard fault: fault high, outputs off
// RL14: soft fault recorded, outputs stay enabled
// RL15: disable toggle clears fault and status
// RL16: master raises select before clocking, msb first
// RL17: frame is exactly sixteen clock cycles
// RL18: write: master drives sixteen bits, drops select
// RL19: address 15:9, read bit 8, data 7:0
// RL20: read: device drives eight bits on rising
// RL21: select low returns machine to idle
// RL22: mode 00 6%, 01 3%, 10 level, 11 max
// RL23: sample on rising, negative step stops at zero
// RL24: foreign address ignored, line left released
package laser_ctrl_pkg;
  localparam logic [4:0] TX_CONTROL_IDX  = 5'h05;
  localparam logic [4:0] HARD_STATUS_IDX = 5'h06;
  localparam logic [4:0] SOFT_STATUS_IDX = 5'h07;
  localparam logic [4:0] BIAS_CODE_IDX   = 5'h08;
  localparam logic [4:0] MOD_CODE_IDX    = 5'h09;
  localparam logic [4:0] MOD_LIMIT_IDX   = 5'h0a;
  localparam logic [4:0] BIAS_LIMIT_IDX  = 5'h0b;
  localparam logic [4:0] MOD_STEP_IDX    = 5'h0c;
  localparam logic [4:0] BIAS_STEP_IDX   = 5'h0d;
  localparam logic [4:0] MODE_CTRL_IDX   = 5'h0e;
  localparam logic [4:0] FAULT_MASK_IDX  = 5'h0f;
  localparam logic [4:0] DEEMPH_IDX      = 5'h10;
  localparam logic [4:0] EQ_IDX          = 5'h11;

  localparam logic [7:0] TX_CONTROL_RST  = 8'h02;
  localparam logic [7:0] BIAS_CODE_RST   = 8'h04;
  localparam logic [7:0] MOD_CODE_RST    = 8'h04;
  localparam logic [7:0] LIMIT_RST       = 8'hff;
  localparam logic [7:0] DEEMPH_RST      = 8'h00;
  localparam logic [7:0] EQ_RST          = 8'h00;

  localparam int TX_EN_BIT   = 0;
  localparam int TX_POL_BIT  = 1;
  localparam int SOFTRES_BIT = 2;
  localparam int DE_MODE_LSB = 3;
  localparam int BIAS_WARN_BIT = 0;
  localparam int MOD_WARN_BIT  = 1;
  localparam logic [1:0] SOFTRES_GUARD = 2'b10;

  localparam logic [4:0] FRAME_BITS  = 5'd16;
  localparam logic [4:0] HEADER_BITS = 5'd8;
  localparam logic [4:0] READ_LAST   = 5'd15;

  // boost in tenths of a dB
  localparam logic [5:0] EQ_BOOST_00 = 6'd10;
  localparam logic [5:0] EQ_BOOST_01 = 6'd30;
  localparam logic [5:0] EQ_BOOST_11 = 6'd55;

  typedef enum logic [1:0] {
    DE_FIXED6, DE_FIXED3, DE_LEVEL, DE_MAX
  } deemph_sel_t;

  typedef enum logic [1:0] {IDLE, RECV, SEND, HOLD} link_state_t;

  typedef struct packed {
    logic [7:0] txControl;
    logic [7:0] hardStatus;
    logic [7:0] softStatus;
    logic [7:0] biasCode;
    logic       biasLsb;
    logic [7:0] modCode;
    logic       modLsb;
    logic [7:0] modLimit;
    logic [7:0] biasLimit;
    logic [7:0] modStep;
    logic [7:0] biasStep;
    logic [7:0] modeCtrl;
    logic [7:0] faultMask;
    logic [7:0] deemphLevel;
    logic [7:0] eqSelect;
  } regs_t;

  localparam regs_t REGS_RST = '{
    txControl: TX_CONTROL_RST, hardStatus: 8'h00, softStatus: 8'h00,
    biasCode: BIAS_CODE_RST, biasLsb: 1'b0, modCode: MOD_CODE_RST,
    modLsb: 1'b0, modLimit: LIMIT_RST, biasLimit: LIMIT_RST,
    modStep: 8'h00, biasStep: 8'h00, modeCtrl: 8'h00,
    faultMask: 8'h00, deemphLevel: DEEMPH_RST, eqSelect: EQ_RST};

  typedef struct packed {
    logic       chipSel;
    logic       serialClk;
    logic       serialData;
    logic       disableIn;
    logic [1:0] strap;
    logic [7:0] hardFault;
    logic [7:0] softFault;
  } pins_t;
endpackage

//--- rtl/pin_sync.sv
// two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_t;

  sync_t st;
  sync_t next_st;

  // first stage feeds only the second stage
  always_comb begin
    next_st.first  = d;
    next_st.second = st.first;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.second;
endmodule
`default_nettype wire

//--- rtl/laser_driver_serial_control.sv
// serial slave, current codes, step logic and fault latching
`timescale 1ns/10ps
`default_nettype none
module laser_driver_serial_control (
  input  wire logic                        clock,
  input  wire logic                        rstn,
  input  wire logic                        chipSelLine,
  input  wire logic                        serialClk,
  input  wire logic                        sdaIn,
  output logic                             sdaOut,
  output logic                             sdaOe,
  input  wire logic [1:0]                  addrStrapPin,
  input  wire logic                        disableIn,
  input  wire logic [7:0]                  hardFaultIn,
  input  wire logic [7:0]                  softFaultIn,
  output logic                             faultOut,
  output logic                             laserEnable,
  output logic                             txPolarity,
  output logic [8:0]                       biasDac,
  output logic [8:0]                       modDac,
  output logic [5:0]                       eqBoost,
  output laser_ctrl_pkg::deemph_sel_t      deemphSel,
  output logic [7:0]                       deemphLevel
);
  import laser_ctrl_pkg::*;

  typedef struct packed {
    link_state_t state;
    logic [15:0] shift;
    logic [4:0]  count;
    logic [7:0]  readData;
    logic        driving;
    logic        sclPrev;
    logic        disPrev;
    logic [1:0]  strapWait;
    logic [1:0]  strap;
    logic        fault;
    regs_t       regs;
  } state_t;

  state_t st;
  state_t next_st;
  pins_t  pinRaw;
  pins_t  pin;

  assign pinRaw = '{chipSel: chipSelLine, serialClk: serialClk,
                    serialData: sdaIn, disableIn: disableIn,
                    strap: addrStrapPin, hardFault: hardFaultIn,
                    softFault: softFaultIn};

  pin_sync #(.W($bits(pins_t))) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     (pinRaw),
    .q     (pin)
  );

  // returns {warn, code}; negative sums stop at zero, no wrap
  function automatic logic [9:0] applyStep(input logic [7:0] upper,
                                           input logic       lsb,
                                           input logic [4:0] step,
                                           input logic [7:0] limit);
    logic [10:0] sum;
    sum = {2'b00, upper, lsb} + {{6{step[4]}}, step}; // [RL4] [RL7]
    if (sum[10]) begin
      applyStep = 10'h000; // [RL23]
    end else if (sum[9:1] > {1'b0, limit}) begin
      applyStep = {1'b1, limit, 1'b0}; // [RL5] [RL8]
    end else begin
      applyStep = {1'b0, sum[8:0]};
    end
  endfunction

  function automatic logic [7:0] regRead(input regs_t r,
                                         input logic [4:0] idx);
    case (idx)
      TX_CONTROL_IDX:  regRead = r.txControl;
      HARD_STATUS_IDX: regRead = r.hardStatus;
      SOFT_STATUS_IDX: regRead = r.softStatus;
      BIAS_CODE_IDX:   regRead = r.biasCode;
      MOD_CODE_IDX:    regRead = r.modCode;
      MOD_LIMIT_IDX:   regRead = r.modLimit;
      BIAS_LIMIT_IDX:  regRead = r.biasLimit;
      MOD_STEP_IDX:    regRead = {r.modLsb, r.modStep[6:0]};
      BIAS_STEP_IDX:   regRead = {r.biasLsb, r.biasStep[6:0]};
      MODE_CTRL_IDX:   regRead = r.modeCtrl;
      FAULT_MASK_IDX:  regRead = r.faultMask;
      DEEMPH_IDX:      regRead = r.deemphLevel;
      EQ_IDX:          regRead = r.eqSelect;
      default:         regRead = 8'h00;
    endcase
  endfunction

  logic        sclRise;
  logic [15:0] newShift;
  logic        addrHit;
  logic        disToggle;
  logic [7:0]  hardEvents;
  logic [9:0]  stepResult;
  logic [7:0]  wData;
  logic [4:0]  wIdx;
  logic [1:0]  warnSet;

  always_comb begin
    next_st    = st;
    sclRise    = pin.serialClk & ~st.sclPrev;
    newShift   = {st.shift[14:0], pin.serialData}; // [RL23] [RL16]
    addrHit    = (newShift[7:6] == st.strap); // [RL24]
    disToggle  = pin.disableIn ^ st.disPrev;
    hardEvents = pin.hardFault & ~st.regs.faultMask;
    stepResult = 10'h000;
    wData      = st.shift[7:0];
    wIdx       = st.shift[13:9]; // [RL19]
    warnSet    = 2'b00;
    next_st.sclPrev = pin.serialClk;
    next_st.disPrev = pin.disableIn;

    // the synchroniser is cleared by reset, so the strap is only
    // final on the third edge after release
    if (!(&st.strapWait)) begin
      next_st.strap     = pin.strap; // [RL12]
      next_st.strapWait = st.strapWait + 2'd1;
    end

    case (st.state)
      IDLE: begin
        next_st.count   = 5'd0;
        next_st.driving = 1'b0;
        if (pin.chipSel) begin
          next_st.state = RECV;
        end
      end
      RECV: begin
        if (sclRise) begin
          next_st.shift = newShift;
          next_st.count = st.count + 5'd1;
          if (st.count + 5'd1 == HEADER_BITS && newShift[0]) begin
            if (addrHit) begin
              next_st.readData = regRead(st.regs, newShift[5:1]);
              next_st.driving  = 1'b1; // [RL20]
            end
            next_st.state = SEND;
          end else if (st.count + 5'd1 == FRAME_BITS) begin
            next_st.state = HOLD; // [RL17]
          end
        end
      end
      SEND: begin
        if (sclRise) begin
          next_st.count    = st.count + 5'd1;
          next_st.readData = {st.readData[6:0], 1'b0};
          if (st.count == READ_LAST) begin
            next_st.driving = 1'b0;
            next_st.state   = HOLD;
          end
        end
      end
      HOLD: begin
        next_st.driving = 1'b0;
      end
      default: begin
        next_st.state = IDLE;
      end
    endcase

    // a completed write frame to our address takes effect once
    if (st.state == RECV && sclRise && st.count + 5'd1 == FRAME_BITS
        && !newShift[8] && newShift[15:14] == st.strap) begin // [RL18]
      wData = newShift[7:0];
      wIdx  = newShift[13:9];
      case (wIdx)
        TX_CONTROL_IDX: begin
          next_st.regs.txControl = wData;
        end
        BIAS_CODE_IDX: begin
          next_st.regs.biasCode = wData; // [RL2]
        end
        MOD_CODE_IDX: begin
          next_st.regs.modCode = wData; // [RL6]
        end
        MOD_LIMIT_IDX: begin
          next_st.regs.modLimit = wData;
        end
        BIAS_LIMIT_IDX: begin
          next_st.regs.biasLimit = wData;
        end
        MOD_STEP_IDX: begin
          next_st.regs.modStep = wData;
          stepResult = applyStep(st.regs.modCode, st.regs.modLsb,
                                 wData[4:0], st.regs.modLimit);
          next_st.regs.modCode = stepResult[8:1];
          next_st.regs.modLsb  = stepResult[0]; // [RL6]
          if (stepResult[9]) begin
            warnSet[MOD_WARN_BIT] = 1'b1; // [RL8]
          end
        end
        BIAS_STEP_IDX: begin
          next_st.regs.biasStep = wData;
          stepResult = applyStep(st.regs.biasCode, st.regs.biasLsb,
                                 wData[4:0], st.regs.biasLimit);
          next_st.regs.biasCode = stepResult[8:1];
          next_st.regs.biasLsb  = stepResult[0]; // [RL3]
          if (stepResult[9]) begin
            warnSet[BIAS_WARN_BIT] = 1'b1; // [RL5]
          end
        end
        MODE_CTRL_IDX: begin
          next_st.regs.modeCtrl = wData;
        end
        FAULT_MASK_IDX: begin
          next_st.regs.faultMask = wData;
        end
        DEEMPH_IDX: begin
          next_st.regs.deemphLevel = wData;
        end
        EQ_IDX: begin
          next_st.regs.eqSelect = wData;
        end
        default: begin
          next_st.regs = next_st.regs;
        end
      endcase
      // guarded soft reset returns every register to default
      if (wIdx == TX_CONTROL_IDX && wData[SOFTRES_BIT]
          && wData[1:0] == SOFTRES_GUARD) begin
        next_st.regs = REGS_RST;
      end
    end

    // select low ends the cycle from any state
    if (!pin.chipSel) begin
      next_st.state   = IDLE; // [RL21]
      next_st.driving = 1'b0;
    end

    // clear by disable toggle; a fresh fault in the same cycle wins
    if (disToggle) begin
      next_st.regs.hardStatus = 8'h00; // [RL15]
      next_st.regs.softStatus = 8'h00;
      next_st.fault           = 1'b0;
    end
    next_st.regs.hardStatus = next_st.regs.hardStatus | hardEvents; // [RL13]
    // clamp warnings join after the clear so that a set wins
    next_st.regs.softStatus = next_st.regs.softStatus
                            | pin.softFault | {6'h00, warnSet}; // [RL14]
    if (|hardEvents) begin
      next_st.fault = 1'b1; // [RL13]
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st      <= '0;
      st.regs <= REGS_RST; // [RL11] [RL3]
    end else begin
      st <= next_st;
    end
  end

  // open drain: only zeros are driven, ones come from the pull-up
  assign sdaOut      = 1'b0;
  assign sdaOe       = st.driving & ~st.readData[7]; // [RL20] [RL24]
  assign faultOut    = st.fault; // [RL15]
  // soft faults never gate the outputs
  assign laserEnable = st.regs.txControl[TX_EN_BIT] & ~st.fault
                     & ~pin.disableIn; // [RL13] [RL14]
  assign txPolarity  = st.regs.txControl[TX_POL_BIT];
  assign biasDac     = {st.regs.biasCode, st.regs.biasLsb};
  assign modDac      = {st.regs.modCode, st.regs.modLsb};
  assign deemphLevel = st.regs.deemphLevel; // [RL10]

  always_comb begin
    case (st.regs.txControl[DE_MODE_LSB +: 2])
      2'b00:   deemphSel = DE_FIXED6; // [RL22]
      2'b01:   deemphSel = DE_FIXED3;
      2'b10:   deemphSel = DE_LEVEL;
      default: deemphSel = DE_MAX;
    endcase
    // code 10 has no documented boost; it reuses the middle setting
    case (st.regs.eqSelect[1:0])
      2'b00:   eqBoost = EQ_BOOST_00; // [RL1]
      2'b11:   eqBoost = EQ_BOOST_11;
      default: eqBoost = EQ_BOOST_01;
    endcase
  end
endmodule
`default_nettype wire

//--- tb/laser_ctrl_asserts.sv
// concurrent checks on the laser driver control ports
`timescale 1ns/10ps
`default_nettype none
module laser_ctrl_asserts
  import laser_ctrl_pkg::*;
(
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       chipSelLine,
  input wire logic       disableIn,
  input wire logic [7:0] hardFaultIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       faultOut,
  input wire logic       laserEnable,
  input wire logic       txPolarity,
  input wire logic [8:0] biasDac,
  input wire logic [8:0] modDac,
  input wire logic [5:0] eqBoost
);
  logic [4:0] disHist;
  logic [4:0] hardSeen;
  logic [3:0] quiet;
  // history covers the pin synchroniser delay
  always_ff @(posedge clock) begin
    disHist <= {disHist[3:0], disableIn};
    hardSeen <= {hardSeen[3:0], |hardFaultIn};
    if (!rstn || chipSelLine) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence csLowRun; (!chipSelLine) [*6]; endsequence
  sequence lineFree8; (!sdaOe) [*8]; endsequence
  AST_RST_VAL: assert property ($rose(rstn) |-> biasDac == 9'h008
    && modDac == 9'h008 && !laserEnable && !faultOut && txPolarity)
    else $error("reset outputs wrong");
  AST_FAULT_OFF: assert property (faultOut |-> !laserEnable)
    else $error("laser on during fault");
  AST_FAULT_CAUSE: assert property ($rose(faultOut) |-> hardSeen != 0)
    else $error("fault without hard fault");
  AST_FAULT_HOLD: assert property (faultOut && $stable(disableIn) &&
    (disHist == 5'h00 || disHist == 5'h1f) |=> faultOut)
    else $error("fault dropped without toggle");
  AST_IDLE: assert property (csLowRun |-> !sdaOe)
    else $error("line driven after select low");
  // drive needs select seen high through the synchroniser
  AST_OPEN_DRAIN: assert property (sdaOe |-> !sdaOut
    && $past(chipSelLine, 3))
    else $error("line driven high");
  AST_CS_START: assert property ($rose(chipSelLine) |-> lineFree8)
    else $error("line driven in header");
  AST_DAC_FRAME: assert property ($changed(biasDac) ||
    $changed(modDac) |-> quiet < 4'h8)
    else $error("code changed outside frame");
  AST_EQ_SET: assert property (eqBoost == EQ_BOOST_00 ||
    eqBoost == EQ_BOOST_01 || eqBoost == EQ_BOOST_11)
    else $error("boost value outside table");
endmodule
bind laser_driver_serial_control laser_ctrl_asserts u_chk (
  .clock(clock), .rstn(rstn), .chipSelLine(chipSelLine),
  .disableIn(disableIn), .hardFaultIn(hardFaultIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .faultOut(faultOut), .laserEnable(laserEnable),
  .txPolarity(txPolarity), .biasDac(biasDac), .modDac(modDac),
  .eqBoost(eqBoost));
`default_nettype wire

//--- tb/serial_master.sv
// three-wire bus master model, timed apart from the system clock
`timescale 1ns/10ps
`default_nettype none
module serial_master (
  input  wire logic sdaLine,
  output logic      chipSelLine,
  output logic      serialClk,
  output logic      sdaPull
);
  initial begin
    chipSelLine = 1'b0;
    serialClk = 1'b0;
    sdaPull = 1'b0;
  end
  // clock stands low outside frames; odd offset keeps edges off clock
  task automatic xfer(input logic [15:0] f, input int nbits,
                      input int half, output logic [7:0] rd);
    rd = 8'h00;
    #1.3 chipSelLine = 1'b1;
    #(half);
    for (int i = 15; i > 15 - nbits; i--) begin
      serialClk = 1'b0;
      sdaPull = (i >= 8 || !f[8]) ? !f[i] : 1'b0;
      #(half);
      if (f[8] && i < 8) rd[i] = sdaLine;
      serialClk = 1'b1;
      #(half);
    end
    serialClk = 1'b0;
    sdaPull = 1'b0;
    #(half) chipSelLine = 1'b0;
    #(half);
  endtask
endmodule
`default_nettype wire

//--- tb/test_laser_driver_serial_control.sv
// self-checking bench for the laser driver serial control block
`timescale 1ns/10ps
`default_nettype none
module test_laser_driver_serial_control;
  import laser_ctrl_pkg::*;
  localparam int HALF = 32;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        disableIn = 1'b0;
  logic [1:0]  strap = 2'b00;
  logic [7:0]  hardF = 8'h00;
  logic [7:0]  softF = 8'h00;
  logic        chip_sel_line, scl, mPull, sdaOut, sdaOe, faultOut, laserEnable;
  logic        txPolarity;
  logic [8:0]  biasDac, modDac;
  logic [5:0]  eqBoost;
  logic [7:0]  deemphLevel, rd;
  deemph_sel_t deemphSel;
  logic [1:0]  eqCode [3] = '{2'b00, 2'b01, 2'b11};
  logic [5:0]  eqExp [3] = '{EQ_BOOST_00, EQ_BOOST_01, EQ_BOOST_11};
  integer      seed = 32'h93e15d47;
  int          errorCnt = 0;
  int          nCompared = 0;
  // pull-up wins unless some party pulls low
  wire         sdaLine = ~(mPull | (sdaOe & ~sdaOut));
  always #2 clock = ~clock;
  serial_master u_master (.sdaLine(sdaLine), .chipSelLine(chip_sel_line),
    .serialClk(scl), .sdaPull(mPull));
  laser_driver_serial_control u_dut (.clock(clock), .rstn(rstn),
    .chipSelLine(chip_sel_line), .serialClk(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrapPin(strap),
    .disableIn(disableIn), .hardFaultIn(hardF), .softFaultIn(softF),
    .faultOut(faultOut), .laserEnable(laserEnable),
    .txPolarity(txPolarity), .biasDac(biasDac), .modDac(modDac),
    .eqBoost(eqBoost), .deemphSel(deemphSel), .deemphLevel(deemphLevel));
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    nCompared++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    u_master.xfer({strap, i, 1'b0, d}, 16, HALF, rd);
    tick(2);
  endtask
  task automatic rdr(input logic [4:0] i, input int half);
    u_master.xfer({strap, i, 1'b1, 8'h00}, 16, half, rd);
    tick(2);
  endtask
  // returns {warn, code}: floor at zero, clamp to {limit, 0}
  function automatic logic [9:0] stepCalc(logic [8:0] c, logic [4:0] s,
                                          logic [7:0] l);
    int v;
    v = int'(c) + int'($signed(s));
    if (v < 0) v = 0;
    if ((v >> 1) > int'(l)) return {1'b1, l, 1'b0};
    return {1'b0, v[8:0]};
  endfunction
  task automatic complete_run;
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic resetChk;
    rstn <= 1'b0;
    tick(6);
    rstn <= 1'b1;
    tick(4);
    chk("biasDac", 9'h008, biasDac);
    chk("modDac", 9'h008, modDac);
    chk("laserEnable", 9'h0, laserEnable);
    chk("txPolarity", 9'h1, txPolarity);
    chk("eqBoost", EQ_BOOST_00, eqBoost);
    chk("deemphSel", DE_FIXED6, deemphSel);
    $display("test reset done");
  endtask
  initial begin
    logic [7:0] lim, d;
    logic [8:0] cur;
    logic [9:0] r;
    logic [4:0] st;
    logic [1:0] w;
    strap = 2'($random(seed));
    resetChk();
    u_master.xfer({~strap, BIAS_CODE_IDX, 1'b0, 8'haa}, 16, HALF, rd);
    tick(2);
    chk("foreignWr", 9'h008, biasDac);
    u_master.xfer({~strap, BIAS_CODE_IDX, 1'b1, 8'h00}, 16, HALF, rd);
    chk("foreignRd", 9'h0ff, rd);
    u_master.xfer({strap, BIAS_CODE_IDX, 1'b0, 8'h55}, 10, HALF, rd);
    tick(2);
    chk("shortFrame", 9'h008, biasDac);
    d = 8'($random(seed));
    wr(BIAS_CODE_IDX, d);
    chk("biasDirect", {d, 1'b0}, biasDac);
    rdr(BIAS_CODE_IDX, 80);
    chk("biasRead", d, rd);
    $display("test link done");
    for (int i = 0; i < 3; i++) begin
      wr(EQ_IDX, {6'h00, eqCode[i]});
      chk("eqBoost", eqExp[i], eqBoost);
    end
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(TX_CONTROL_IDX, {3'b000, 2'(i), 3'b010});
      wr(DEEMPH_IDX, d);
      chk("deemphSel", 9'(i), deemphSel);
      chk("deemphLevel", d, deemphLevel);
    end
    $display("test analog done");
    w = 2'b00;
    for (int k = 0; k < 2; k++) begin
      lim = 8'h10 | 8'($random(seed) & 8'h3f);
      wr(k ? MOD_LIMIT_IDX : BIAS_LIMIT_IDX, lim);
      wr(k ? MOD_CODE_IDX : BIAS_CODE_IDX, 8'h03);
      cur = 9'h006;
      for (int i = 0; i < 25; i++) begin
        st = (i == 0) ? 5'h10 : (i % 3 != 0) ? 5'h0f : 5'($random(seed));
        wr(k ? MOD_STEP_IDX : BIAS_STEP_IDX, {3'b000, st});
        r = stepCalc(cur, st, lim);
        cur = r[8:0];
        w[k] = w[k] | r[9];
        chk("stepDac", cur, k ? modDac : biasDac);
      end
    end
    rdr(SOFT_STATUS_IDX, HALF);
    chk("clampWarn", {7'h00, w}, rd);
    $display("test steps done");
    wr(TX_CONTROL_IDX, 8'h03);
    softF <= 8'h80 | 8'($random(seed));
    tick(8);
    chk("laserEnable", 9'h1, laserEnable);
    rdr(SOFT_STATUS_IDX, HALF);
    chk("softStatus", softF | {6'h00, w}, rd);
    softF <= 8'h00;
    hardF <= 8'h01 << st[2:0];
    tick(8);
    chk("faultOut", 9'h1, faultOut);
    chk("laserOff", 9'h0, laserEnable);
    d = hardF;
    hardF <= 8'h00;
    tick(8);
    chk("faultHeld", 9'h1, faultOut);
    rdr(HARD_STATUS_IDX, HALF);
    chk("hardStatus", d, rd);
    disableIn <= 1'b1;
    tick(8);
    chk("faultClr", 9'h0, faultOut);
    rdr(HARD_STATUS_IDX, HALF);
    chk("hardClr", 9'h0, rd);
    rdr(SOFT_STATUS_IDX, HALF);
    chk("softClr", 9'h0, rd);
    disableIn <= 1'b0;
    wr(FAULT_MASK_IDX, 8'hff);
    hardF <= 8'hff;
    tick(8);
    chk("masked", 9'h0, faultOut);
    hardF <= 8'h00;
    wr(TX_CONTROL_IDX, 8'h06);
    chk("softResMod", 9'h008, modDac);
    chk("softResEn", 9'h0, laserEnable);
    rdr(FAULT_MASK_IDX, HALF);
    chk("softResMask", 9'h0, rd);
    $display("test faults done");
    resetChk();
    complete_run();
  end
  // about 80 frames of roughly 1.1 us each, with margin
  initial begin
    #300000;
    errorCnt++;
    complete_run();
  end
endmodule
`default_nettype wire
